// ### src/port_pkg.sv
// Purpose: shared constants for the port pin block
// Assumes: port commands arrive already decoded from the command decoder
// Notes: bit 0 of the port is the anti-shock reset, never a general pin
package port_pkg;
	localparam int PORT_W          = 3;
	localparam int RST_BIT         = 0;
	localparam int PIN_TWO_BIT     = 2;
	localparam logic [2:0] DIR_RST = 3'h0;
	localparam logic [2:0] LVL_RST = 3'h0;
	localparam logic       ASR_ASSERTED = 1'h0;
	localparam logic [2:0] SYNC_RST     = 3'h0;
	localparam logic [2:0] RD_RST       = 3'h0;
endpackage

// ### src/sync2.sv
// Purpose: two-stage synchroniser for pin inputs
// Assumes: single clock mclk
// Notes: first stage is read only by the second
`timescale 1ns/100ps
module sync2 #(
	parameter int           W       = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	// clock and reset
	input  wire logic         mclk,
	input  wire logic         resetn,
	// data
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_r;
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			meta_r <= RST_VAL;
			q      <= RST_VAL;
		end else begin
			meta_r <= d;
			q      <= meta_r;
		end
	end
endmodule

// ### src/antishock_reset_and_port_pins.sv
// Purpose: general port bits and the anti-shock reset pin
// Assumes: host port commands arrive as a decoded one-cycle strobe with data
// Notes: anti-shock reset reaches only the anti-shock section
// What this block does
// - low reset pin holds only anti-shock section
// - high reset pin releases anti-shock section
// - port bit zero is reset, not general
// - port set forces bit zero off, undriven
// - pin two direction and level from host
`timescale 1ns/100ps
module antishock_reset_and_port_pins
	import port_pkg::*;
(
	// clock and reset
	input  wire logic              mclk,
	input  wire logic              resetn,
	// port set command from decoder
	input  wire logic              port_set_stb,
	input  wire logic [PORT_W-1:0] port_dir_in,
	input  wire logic [PORT_W-1:0] port_lvl_in,
	// port pins, bit 0 is antishock_reset_n
	input  wire logic [PORT_W-1:0] port_pin_i,
	output logic      [PORT_W-1:0] port_pin_o,
	output logic      [PORT_W-1:0] port_pin_oe,
	// readback seen by the host: synchronised pad level on inputs, own level on outputs, zero at bit 0
	output logic      [PORT_W-1:0] port_rd_r,
	// reset toward anti-shock section only
	output logic                   antishock_rst_n_r
);
	// pad levels after the two-stage synchroniser
	logic [PORT_W-1:0] pin_s;
	// command state, held between strobes
	logic [PORT_W-1:0] dir_r;
	logic [PORT_W-1:0] lvl_r;
	logic [PORT_W-1:0] dir_nxt;
	logic [PORT_W-1:0] lvl_nxt;
	// per-bit pad and readback values, registered below
	logic [PORT_W-1:0] pin_o_nxt;
	logic [PORT_W-1:0] rd_nxt;

	// pads are asynchronous to mclk; only the reset pin checks read them raw
	sync2 #(
		.W       (PORT_W),
		.RST_VAL (SYNC_RST)
	) u_sync (
		.mclk   (mclk),
		.resetn (resetn),
		.d      (port_pin_i),
		.q      (pin_s)
	);

	// step sequences shared by the checks
	// a command is taken on the edge that sees the strobe
	sequence s_cmd_taken;
		port_set_stb;
	endsequence

	// two quiet edges: nothing can reach the pads after them
	sequence s_no_cmd_two;
		!port_set_stb ##1 !port_set_stb;
	endsequence

	// reset pad low long enough to cross the synchroniser
	sequence s_pad_low3;
		!port_pin_i[RST_BIT] [*3];
	endsequence

	// reset pad high long enough to cross the synchroniser
	sequence s_pad_high4;
		port_pin_i[RST_BIT] [*4];
	endsequence

	// reset pin slot: never latched, never driven, reads as zero
	assign dir_nxt[RST_BIT]   = 1'b0;
	assign lvl_nxt[RST_BIT]   = 1'b0;
	assign pin_o_nxt[RST_BIT] = 1'b0;
	assign rd_nxt[RST_BIT]    = 1'b0;

	// general bits share one slice each
	for (genvar i = 1; i < PORT_W; i++) begin : g_bit
		assign dir_nxt[i]   = port_dir_in[i];
		assign lvl_nxt[i]   = port_lvl_in[i];
		// level reaches the pad only while the driver is on
		assign pin_o_nxt[i] = lvl_r[i] & dir_r[i];
		// outputs read back their own level, inputs the pad
		assign rd_nxt[i]    = dir_r[i] ? lvl_r[i] : pin_s[i];

		a_bit_rd_out: assert property (@(posedge mclk) disable iff (!resetn)
			dir_r[i] |=> (port_rd_r[i] == $past(lvl_r[i])))
			else $error("output bit read back wrong");

		a_bit_rd_in: assert property (@(posedge mclk) disable iff (!resetn)
			!dir_r[i] |=> (port_rd_r[i] == $past(pin_s[i])))
			else $error("input bit read back wrong");

		a_bit_oe_cfg: assert property (@(posedge mclk) disable iff (!resetn)
			s_cmd_taken |-> ##2 (port_pin_oe[i] == $past(port_dir_in[i], 2)))
			else $error("bit direction not applied");

		a_bit_lvl_cfg: assert property (@(posedge mclk) disable iff (!resetn)
			s_cmd_taken |-> ##2 (port_pin_o[i] == ($past(port_dir_in[i], 2) & $past(port_lvl_in[i], 2))))
			else $error("bit level not applied");
	end

	// command latch; bit zero already forced by the slice above
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			dir_r <= DIR_RST;
			lvl_r <= LVL_RST;
		end else if (port_set_stb) begin
			dir_r <= dir_nxt;
			lvl_r <= lvl_nxt;
		end
	end

	// pads registered so outputs leave straight from flops
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			port_pin_o  <= LVL_RST;
			port_pin_oe <= DIR_RST;
		end else begin
			port_pin_o  <= pin_o_nxt;
			port_pin_oe <= dir_r;
		end
	end

	// one extra edge of latency, but a clean readback flop
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			port_rd_r <= RD_RST;
		end else begin
			port_rd_r <= rd_nxt;
		end
	end

	// dsp part keeps running; only this output follows the pin
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			antishock_rst_n_r <= ASR_ASSERTED;
		end else begin
			antishock_rst_n_r <= pin_s[RST_BIT];
		end
	end

	// reset pin slot checks
	a_bit0_undriven: assert property (@(posedge mclk) disable iff (!resetn)
		!port_pin_oe[RST_BIT] && !port_pin_o[RST_BIT])
		else $error("bit zero driven");

	a_latch_zero: assert property (@(posedge mclk) disable iff (!resetn)
		!dir_r[RST_BIT] && !lvl_r[RST_BIT])
		else $error("bit zero latched");

	a_rd_bit0: assert property (@(posedge mclk) disable iff (!resetn)
		!port_rd_r[RST_BIT])
		else $error("bit zero read as general");

	// anti-shock reset: two sync edges plus one output edge
	a_rst_follow: assert property (@(posedge mclk) disable iff (!resetn)
		$fell(port_pin_i[RST_BIT]) |-> ##[1:4] !antishock_rst_n_r)
		else $error("antishock reset not asserted");

	a_rst_hold: assert property (@(posedge mclk) disable iff (!resetn)
		s_pad_low3 |=> !antishock_rst_n_r)
		else $error("antishock reset not held");

	a_rst_release: assert property (@(posedge mclk) disable iff (!resetn)
		s_pad_high4 |=> antishock_rst_n_r)
		else $error("antishock reset not released");

	// the reset pin must not disturb the port configuration
	a_cfg_steady: assert property (@(posedge mclk) disable iff (!resetn)
		s_no_cmd_two |=> ($stable(port_pin_oe) && $stable(port_pin_o)))
		else $error("port changed without command");

	// strobe edge, latch edge, pad edge
	a_pin2_cfg: assert property (@(posedge mclk) disable iff (!resetn)
		s_cmd_taken |-> ##2 (port_pin_oe[PIN_TWO_BIT] == $past(port_dir_in[PIN_TWO_BIT], 2)))
		else $error("pin two direction wrong");

	a_o_cause: assert property (@(posedge mclk) disable iff (!resetn)
		$rose(port_pin_o[PIN_TWO_BIT]) |-> $past(port_set_stb, 2))
		else $error("pin two level without command");

	a_rd_pin2: assert property (@(posedge mclk) disable iff (!resetn)
		port_pin_oe[PIN_TWO_BIT] |-> (port_rd_r[PIN_TWO_BIT] == port_pin_o[PIN_TWO_BIT]))
		else $error("pin two readback wrong");

	// pin two driver moves only on command, and no driver carries a level while off
	a_oe_cause: assert property (@(posedge mclk) disable iff (!resetn)
		$rose(port_pin_oe[PIN_TWO_BIT]) |-> $past(port_set_stb, 2))
		else $error("driver enabled without command");

	a_oe_drop: assert property (@(posedge mclk) disable iff (!resetn)
		$fell(port_pin_oe[PIN_TWO_BIT]) |-> $past(port_set_stb, 2))
		else $error("driver disabled without command");

	a_o_needs_oe: assert property (@(posedge mclk) disable iff (!resetn)
		!(|(port_pin_o & ~port_pin_oe)))
		else $error("level on undriven pin");
endmodule

// ### verif/host_cmd_model.sv
// Purpose: host issuing port set commands
// Assumes: strobe one cycle per command
// Notes: none
`timescale 1ns/100ps
module host_cmd_model (
	input  wire logic       mclk,
	input  wire logic       go,
	input  wire logic [2:0] dir,
	input  wire logic [2:0] lvl,
	output logic            stb,
	output logic      [2:0] dir_o,
	output logic      [2:0] lvl_o
);
	always_ff @(posedge mclk) begin
		stb   <= go;
		dir_o <= dir;
		lvl_o <= lvl;
	end
endmodule

// ### verif/antishock_reset_and_port_pins_tb.sv
// Purpose: bench for the port pin block
// Assumes: 8 ns mclk
// Notes: bit0 fields random to show they are ignored
`timescale 1ns/100ps
module antishock_reset_and_port_pins_tb;
	logic       mclk = 0, resetn = 0, go = 0, stb, run = 0, ars;
	logic [2:0] dir = 0, lvl = 0, pin = 0, di, li, o, oe, rd, p = 0, md = 0, ml = 0;
	logic [8:0] h = 0;
	logic [9:0] r;
	logic [5:0] e;
	logic [5:0] q[$];
	int         n_mismatch = 0, checks = 0;
	always #4 mclk = ~mclk;
	host_cmd_model host_u (.mclk(mclk), .go(go), .dir(dir), .lvl(lvl), .stb(stb), .dir_o(di), .lvl_o(li));
	antishock_reset_and_port_pins dut_u (.mclk(mclk), .resetn(resetn), .port_set_stb(stb),
		.port_dir_in(di), .port_lvl_in(li), .port_pin_i(pin), .port_pin_o(o), .port_pin_oe(oe),
		.port_rd_r(rd), .antishock_rst_n_r(ars));
	task automatic cmp(input logic [2:0] s, input logic [2:0] x);
		checks++;
		if (s !== x) begin
			n_mismatch++;
			$display("[ERR] %0t seen %b want %b", $time, s, x);
		end
	endtask
	task automatic end_of_test;
		if (q.size() != 0) n_mismatch++;
		$display("mismatches %0d checks %0d", n_mismatch, checks);
		if (n_mismatch == 0 && checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// negedge keeps sampling clear of the launching edge
	always @(negedge mclk) begin
		if (p[1]) begin
			e = q.pop_front();
			md = e[5:3] & 3'h6;
			ml = e[2:0];
		end
		if (run) begin
			cmp(oe, md);
			cmp(o, md & ml);
			cmp(rd, (md & ml) | (~md & h[8:6] & 3'h6));
			cmp({rd[0], oe[0], ars}, {2'h0, h[6]});
		end
		p <= {p[1:0], stb};
		h <= {h[5:0], pin};
	end
	initial begin
		void'($urandom(15584));
		repeat (8) @(posedge mclk);
		cmp(oe, 3'h0);
		resetn <= 1;
		repeat (4) @(posedge mclk);
		run <= 1;
		repeat (300) begin
			@(posedge mclk);
			r = 10'($urandom);
			go <= r[9];
			dir <= r[5:3];
			lvl <= r[2:0];
			pin <= {r[8:7], r[6] | r[9]};
			if (r[9]) q.push_back(r[5:0]);
		end
		repeat (40) begin
			@(posedge mclk);
			r = 10'($urandom);
			go <= r[9];
			dir <= {r[5], 1'b0, r[3]};
			lvl <= r[2:0];
			pin <= {r[8], 2'h0};
			if (r[9]) q.push_back({r[5], 1'b0, r[3], r[2:0]});
		end
		go <= 0;
		repeat (6) @(posedge mclk);
		end_of_test();
	end
	initial begin
		#5000;
		n_mismatch++;
		end_of_test();
	end
endmodule
